/* hdl/pimb_pkg.sv */
// Constants and carrier types for the interrupt mask bank
package pimb_pkg;

	// ****************************************************
	// Register map
	// ****************************************************
	localparam int REG_AW = 8;
	localparam int REG_DW = 8;
	localparam logic [7:0] ADDR_DEV_MASK = 8'h19;
	localparam logic [7:0] ADDR_OV_MASK = 8'h1A;
	localparam logic [7:0] DEV_MASK_RST = 8'h00;
	localparam logic [7:0] OV_MASK_RST = 8'h00;
	// Implemented bits; the rest read zero
	localparam logic [7:0] DEV_MASK_IMPL = 8'h33;
	localparam logic [7:0] OV_MASK_IMPL = 8'h0F;
	localparam logic [7:0] RDATA_IDLE = 8'h00;

	// ****************************************************
	// Field positions
	// ****************************************************
	localparam int BIT_THERMAL_WARN = 5;
	localparam int BIT_THERMAL_PREWARN = 4;
	localparam int BIT_BUS_ERROR = 1;
	localparam int BIT_OV_DETECT = 0;
	localparam int BIT_LINREG = 3;
	localparam int BIT_BUCK3 = 2;
	localparam int BIT_BUCK2 = 1;
	localparam int BIT_BUCK1 = 0;
	localparam int NUM_RAILS = 4;

	// ****************************************************
	// Carriers
	// ****************************************************
	// Request from the serial engine, same clock
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pimb_reg_req_t;

	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
	} pimb_reg_rsp_t;

	// Analog fault comparators, asynchronous to mclk
	typedef struct packed {
		logic thermal_warn;
		logic thermal_prewarn;
		logic overvoltage_detect;
		logic [3:0] rail_ov;
	} pimb_fault_t;

	localparam int FAULT_W = $bits(pimb_fault_t);

	typedef enum logic [2:0] {
		ST_QUIET = 3'b001,
		ST_ALERT = 3'b010,
		ST_FORCED = 3'b100
	} pimb_state_t;

endpackage

/* hdl/pimb_sync.sv */
// Multi-stage level synchroniser for asynchronous fault inputs
`timescale 1ns/1ps
`default_nettype none
module pimb_sync #(
	parameter int WIDTH = 1,
	parameter int STAGES = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output var logic [WIDTH-1:0] q
);

	// Fewer than two stages would leave metastability unfiltered
	if (STAGES < 2 || WIDTH < 1) begin : g_bad_params
		$error("pimb_sync: STAGES must be >= 2 and WIDTH >= 1");
	end

	logic [WIDTH-1:0] stage_r [STAGES];

	// Each stage only feeds the next one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_r[i] <= '0;
			end
		end else begin
			stage_r[0] <= d;
			for (int i = 1; i < STAGES; i++) begin
				stage_r[i] <= stage_r[i-1];
			end
		end
	end

	assign q = stage_r[STAGES-1];

endmodule
`default_nettype wire

/* hdl/pimb_top.sv */
// Interrupt mask bank: mask registers, fault gating and interrupt pin
// ****************************************************
// Operation
// - Mask bit zero lets its source interrupt; one suppresses it.
// - Device mask bit 5 gates the thermal shutdown warning.
// - Device mask bit 4 gates the thermal shutdown pre-warning.
// - Device mask bit 1 gates the serial bus communication error.
// - Fuse option disables bus error detection entirely, not only its interrupt.
// - Device mask bit 0 gates overvoltage detect; fuse may disable detection.
// - Rail mask bit 3 gates the linear regulator overvoltage monitor.
// - Rail mask bit 2 gates the third buck overvoltage monitor.
// - Rail mask bit 1 gates the second buck overvoltage monitor.
// - Rail mask bit 0 gates the first buck overvoltage monitor.
// - A rail in safe state passes its overvoltage fault despite its mask.
// - Interrupt pin follows fault state unless forced low by control.
// ****************************************************
`timescale 1ns/1ps
`default_nettype none
module pimb_top
	import pimb_pkg::*;
#(
	parameter int SYNC_STAGES = 2
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire pimb_reg_req_t reg_req,
	output var pimb_reg_rsp_t reg_rsp,
	input wire pimb_fault_t fault_in,
	input wire logic bus_error,
	input wire logic bus_error_detect_off,
	input wire logic overvoltage_detect_off,
	input wire logic [NUM_RAILS-1:0] rail_safe_state,
	input wire logic force_interrupt_low,
	output var logic bus_error_detect_en,
	output var logic overvoltage_detect_en,
	output var logic interrupt_out_n
);

	// ****************************************************
	// Elaboration checks
	// ****************************************************
	// Refuse a synchroniser too short to filter metastability
	if (SYNC_STAGES < 2) begin : g_bad_stages
		$error("pimb_top: SYNC_STAGES must be at least 2");
	end

	// ****************************************************
	// Reset release
	// ****************************************************
	logic rst_meta_r;
	logic rst_n;

	// Assert at once, release two edges later
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// One clock domain: every assertion below uses this clock and reset
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// ****************************************************
	// Fault input synchronisers
	// ****************************************************
	logic [FAULT_W-1:0] fault_raw;
	logic [FAULT_W-1:0] fault_q;
	pimb_fault_t fault_s;

	assign fault_raw = fault_in;
	assign fault_s = fault_q;

	pimb_sync #(
		.WIDTH(FAULT_W),
		.STAGES(SYNC_STAGES)
	) u_fault_sync (
		.clk(mclk),
		.rst_n(rst_n),
		.d(fault_raw),
		.q(fault_q)
	);

	// ****************************************************
	// Register decode
	// ****************************************************
	function automatic logic hits(input logic [7:0] a, input logic [7:0] target);
		hits = (a == target);
	endfunction

	logic [7:0] dev_mask_r;
	logic [7:0] ov_mask_r;
	logic [7:0] rdata_nxt;

	// Device-level mask; only the four live bits store
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dev_mask_r <= DEV_MASK_RST;
		end else if (reg_req.wr && hits(reg_req.addr, ADDR_DEV_MASK)) begin
			dev_mask_r <= reg_req.wdata & DEV_MASK_IMPL;
		end
	end

	// Rail overvoltage mask
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ov_mask_r <= OV_MASK_RST;
		end else if (reg_req.wr && hits(reg_req.addr, ADDR_OV_MASK)) begin
			ov_mask_r <= reg_req.wdata & OV_MASK_IMPL;
		end
	end

	// Read mux; unmapped addresses answer zero
	always_comb begin
		rdata_nxt = RDATA_IDLE;
		if (reg_req.rd) begin
			if (hits(reg_req.addr, ADDR_DEV_MASK)) begin
				rdata_nxt = dev_mask_r & DEV_MASK_IMPL;
			end else if (hits(reg_req.addr, ADDR_OV_MASK)) begin
				rdata_nxt = ov_mask_r & OV_MASK_IMPL;
			end
		end
	end

	// One-cycle answer to every read or write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rsp <= '0;
		end else begin
			reg_rsp.ack <= reg_req.rd | reg_req.wr;
			reg_rsp.rdata <= rdata_nxt;
		end
	end

	// ****************************************************
	// Detection enables from fuse options
	// ****************************************************
	// Registered so the detectors see a clean level
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_error_detect_en <= 1'b0;
			overvoltage_detect_en <= 1'b0;
		end else begin
			bus_error_detect_en <= ~bus_error_detect_off;
			overvoltage_detect_en <= ~overvoltage_detect_off;
		end
	end

	// ****************************************************
	// Source gating
	// ****************************************************
	logic [7:0] dev_hit;
	logic [NUM_RAILS-1:0] rail_hit;
	logic any_hit;

	// A one in a mask bit blocks its source
	always_comb begin
		dev_hit = 8'h00;
		dev_hit[BIT_THERMAL_WARN] = fault_s.thermal_warn & ~dev_mask_r[BIT_THERMAL_WARN];
		dev_hit[BIT_THERMAL_PREWARN] = fault_s.thermal_prewarn
			& ~dev_mask_r[BIT_THERMAL_PREWARN];
		// Disabled detection also kills the source, not just the interrupt
		dev_hit[BIT_BUS_ERROR] = bus_error & ~bus_error_detect_off
			& ~dev_mask_r[BIT_BUS_ERROR];
		dev_hit[BIT_OV_DETECT] = fault_s.overvoltage_detect & ~overvoltage_detect_off
			& ~dev_mask_r[BIT_OV_DETECT];
	end

	// Safe state overrides the mask for that rail
	always_comb begin
		for (int i = 0; i < NUM_RAILS; i++) begin
			rail_hit[i] = fault_s.rail_ov[i] & (~ov_mask_r[i] | rail_safe_state[i]);
		end
	end

	// Bit order: linreg 3, buck3 2, buck2 1, buck1 0
	assign any_hit = (|dev_hit) | (|rail_hit);

	// ****************************************************
	// Fault state machine and pin
	// ****************************************************
	pimb_state_t state_r;
	pimb_state_t state_nxt;
	logic int_n_nxt;

	// Force wins over the fault state
	always_comb begin
		case (state_r)
			ST_QUIET,
			ST_ALERT,
			ST_FORCED: begin
				if (force_interrupt_low) begin
					state_nxt = ST_FORCED;
				end else if (any_hit) begin
					state_nxt = ST_ALERT;
				end else begin
					state_nxt = ST_QUIET;
				end
			end
			default: begin
				state_nxt = ST_QUIET;
			end
		endcase
		int_n_nxt = (state_nxt == ST_QUIET);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_QUIET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Pin idles high; low means an unmasked fault or a force
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_out_n <= 1'b1;
		end else begin
			interrupt_out_n <= int_n_nxt;
		end
	end

	// ****************************************************
	// Assertions
	// ****************************************************
	// Everything masked, nothing forced: pin stays high
	a_all_masked_quiet: assert property (
		(dev_mask_r == DEV_MASK_IMPL && ov_mask_r == OV_MASK_IMPL
			&& rail_safe_state == '0 && !force_interrupt_low) |=> interrupt_out_n)
		else $error("pin low while all sources masked");

	a_thermal_warn_pass: assert property (
		(fault_s.thermal_warn && !dev_mask_r[5]) |=> !interrupt_out_n)
		else $error("unmasked thermal warning did not pull pin low");

	a_prewarn_pass: assert property (
		(fault_s.thermal_prewarn && !dev_mask_r[4]) |=> !interrupt_out_n)
		else $error("unmasked thermal pre-warning did not pull pin low");

	a_bus_err_pass: assert property (
		(bus_error && !bus_error_detect_off && !dev_mask_r[1]) |=> !interrupt_out_n)
		else $error("unmasked bus error did not pull pin low");

	// Only source is a bus error with detection fused off
	sequence s_lone_bus_error;
		bus_error && bus_error_detect_off && fault_s == '0 && !force_interrupt_low;
	endsequence

	a_bus_err_fused: assert property (
		s_lone_bus_error |=> interrupt_out_n && !bus_error_detect_en)
		else $error("fused-off bus error reached the pin");

	a_ov_detect_pass: assert property (
		(fault_s.overvoltage_detect && !overvoltage_detect_off
			&& !dev_mask_r[BIT_OV_DETECT]) |=> !interrupt_out_n)
		else $error("unmasked overvoltage detect did not pull pin low");

	a_ov_detect_fused: assert property (
		(overvoltage_detect_off && !bus_error && fault_s.rail_ov == '0
			&& !fault_s.thermal_warn && !fault_s.thermal_prewarn
			&& !force_interrupt_low) |=> interrupt_out_n)
		else $error("fused-off overvoltage detect reached the pin");

	a_linreg_pass: assert property (
		(fault_s.rail_ov[3] && !ov_mask_r[3]) |=> !interrupt_out_n)
		else $error("linear regulator overvoltage did not pull pin low");

	a_buck3_pass: assert property (
		(fault_s.rail_ov[2] && !ov_mask_r[2]) |=> !interrupt_out_n)
		else $error("buck3 overvoltage did not pull pin low");

	a_buck2_pass: assert property (
		(fault_s.rail_ov[1] && !ov_mask_r[1]) |=> !interrupt_out_n)
		else $error("buck2 overvoltage did not pull pin low");

	a_buck1_pass: assert property (
		(fault_s.rail_ov[0] && !ov_mask_r[0]) |=> !interrupt_out_n)
		else $error("buck1 overvoltage did not pull pin low");

	// Masked rail fault with safe state set still goes through
	sequence s_safe_masked_fault;
		(fault_s.rail_ov & ov_mask_r[3:0] & rail_safe_state) != '0;
	endsequence

	a_safe_overrides: assert property (
		s_safe_masked_fault |=> !interrupt_out_n
			&& (state_r == ST_ALERT || state_r == ST_FORCED))
		else $error("safe-state rail fault was masked");

	a_force_low: assert property (
		force_interrupt_low [*2] |=> !interrupt_out_n && state_r == ST_FORCED)
		else $error("forced interrupt did not hold pin low");

	a_release_force: assert property (
		$fell(force_interrupt_low) && !any_hit |=> interrupt_out_n)
		else $error("pin stayed low after force released with no fault");

	a_unused_zero: assert property (
		reg_rsp.ack |-> (reg_rsp.rdata & ~(DEV_MASK_IMPL | OV_MASK_IMPL)) == 8'h00
			&& (dev_mask_r & ~DEV_MASK_IMPL) == 8'h00 && (ov_mask_r & ~OV_MASK_IMPL) == 8'h00)
		else $error("unused mask bit stored or read back as one");

	a_write_readback: assert property (
		(reg_req.wr && reg_req.addr == ADDR_OV_MASK) ##1
			(reg_req.rd && !reg_req.wr && reg_req.addr == ADDR_OV_MASK)
			|=> reg_rsp.ack && reg_rsp.rdata == ($past(reg_req.wdata, 2) & OV_MASK_IMPL))
		else $error("rail mask read back differs from masked write");

endmodule
`default_nettype wire

/* test/pimb_host.sv */
// Host controller model driving the register port of the mask bank
`timescale 1ns/1ps
`default_nettype none
module pimb_host
	import pimb_pkg::*;
(
	input wire logic mclk,
	input wire pimb_reg_rsp_t reg_rsp,
	output var pimb_reg_req_t reg_req
);
	// Idle port until the first access
	initial begin
		reg_req = '0;
	end

	// One strobe cycle, answer taken at the following falling edge
	task automatic access(input logic wr, input logic rd, input logic [7:0] addr,
		input logic [7:0] wdata, output logic ack, output logic [7:0] rdata);
		@(negedge mclk);
		reg_req = {wr, rd, addr, wdata};
		@(negedge mclk);
		ack = reg_rsp.ack;
		rdata = reg_rsp.rdata;
		// Address inverted after release so stale values cannot match
		reg_req = {2'b00, ~addr, ~wdata};
	endtask

	// Write strobe, then a read strobe on the very next edge with no idle cycle
	task automatic write_read(input logic [7:0] addr, input logic [7:0] wdata,
		output logic wr_ack, output logic rd_ack, output logic [7:0] rdata);
		@(negedge mclk);
		reg_req = {2'b10, addr, wdata};
		@(negedge mclk);
		wr_ack = reg_rsp.ack;
		reg_req = {2'b01, addr, ~wdata};
		@(negedge mclk);
		rd_ack = reg_rsp.ack;
		rdata = reg_rsp.rdata;
		reg_req = {2'b00, ~addr, ~wdata};
	endtask
endmodule
`default_nettype wire

/* test/pmic_interrupt_mask_bank_tb_top.sv */
// Self-checking bench for the interrupt mask bank
`timescale 1ns/1ps
`default_nettype none
module pmic_interrupt_mask_bank_tb_top
	import pimb_pkg::*;
;
	// ****************************************************
	// Signals and rows
	// ****************************************************
	typedef struct packed {
		logic [7:0] dm;
		logic [7:0] om;
		logic [6:0] flt;
		logic be;
		logic beo;
		logic ovo;
		logic [3:0] safe;
		logic pin;
	} pimb_row_t;
	logic mclk;
	logic arst_n;
	pimb_reg_req_t reg_req;
	pimb_reg_rsp_t reg_rsp;
	pimb_fault_t fault_in;
	logic bus_error;
	logic beo;
	logic ovo;
	logic [3:0] safe;
	logic force_low;
	logic be_en;
	logic ov_det_en;
	logic interrupt_out_n;
	logic wr_ack;
	logic rd_ack;
	logic [7:0] rd_val;
	int error_cnt;
	int num_checks;
	// Masks, faults {warn,prewarn,ovd,rails}, bus error, fuses, safe, pin
	pimb_row_t rows [16] = '{
		{8'h20, 8'h00, 7'h40, 3'b000, 4'h0, 1'b1},
		{8'h10, 8'h00, 7'h40, 3'b000, 4'h0, 1'b0},
		{8'h10, 8'h00, 7'h20, 3'b000, 4'h0, 1'b1},
		{8'h20, 8'h00, 7'h20, 3'b000, 4'h0, 1'b0},
		{8'h02, 8'h00, 7'h00, 3'b100, 4'h0, 1'b1},
		{8'h01, 8'h00, 7'h00, 3'b100, 4'h0, 1'b0},
		{8'h00, 8'h00, 7'h00, 3'b110, 4'h0, 1'b1},
		{8'h01, 8'h00, 7'h10, 3'b000, 4'h0, 1'b1},
		{8'h00, 8'h00, 7'h10, 3'b001, 4'h0, 1'b1},
		{8'h00, 8'h00, 7'h10, 3'b000, 4'h0, 1'b0},
		{8'h00, 8'h08, 7'h08, 3'b000, 4'h0, 1'b1},
		{8'h00, 8'h04, 7'h04, 3'b000, 4'h0, 1'b1},
		{8'h00, 8'h02, 7'h02, 3'b000, 4'h0, 1'b1},
		{8'h00, 8'h01, 7'h01, 3'b000, 4'h0, 1'b1},
		{8'h00, 8'h0E, 7'h01, 3'b000, 4'h0, 1'b0},
		{8'h00, 8'h0F, 7'h0F, 3'b000, 4'h4, 1'b0}
	};

	always #4 mclk = ~mclk;

	pimb_top pimb_top_inst (
		.mclk(mclk),
		.arst_n(arst_n),
		.reg_req(reg_req),
		.reg_rsp(reg_rsp),
		.fault_in(fault_in),
		.bus_error(bus_error),
		.bus_error_detect_off(beo),
		.overvoltage_detect_off(ovo),
		.rail_safe_state(safe),
		.force_interrupt_low(force_low),
		.bus_error_detect_en(be_en),
		.overvoltage_detect_en(ov_det_en),
		.interrupt_out_n(interrupt_out_n)
	);

	pimb_host pimb_host_inst (
		.mclk(mclk),
		.reg_rsp(reg_rsp),
		.reg_req(reg_req)
	);

	// ****************************************************
	// Helpers
	// ****************************************************
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Every access must be answered one edge later
	task automatic reg_rw(input logic wr, input logic rd, input logic [7:0] addr,
		input logic [7:0] wdata, input logic [7:0] exp);
		logic ack;
		logic [7:0] rdata;
		pimb_host_inst.access(wr, rd, addr, wdata, ack, rdata);
		check({7'h00, ack}, 8'h01);
		check(rdata, exp);
	endtask

	// Async faults need a few edges; then the level must hold
	task automatic pin_is(input logic exp);
		int i;
		for (i = 0; i < 8 && interrupt_out_n !== exp; i++) begin
			@(negedge mclk);
		end
		if (interrupt_out_n !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, interrupt_out_n, exp);
			error_cnt++;
			finish_test();
		end
		repeat (4) @(negedge mclk);
		check({7'h00, interrupt_out_n}, {7'h00, exp});
	endtask

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		mclk = 1'b0;
		arst_n = 1'b0;
		fault_in = '0;
		{bus_error, beo, ovo, safe, force_low} = '0;
		error_cnt = 0;
		num_checks = 0;
		repeat (20) @(negedge mclk);
		arst_n = 1'b1;
		repeat (3) @(negedge mclk);
		reg_rw(1'b0, 1'b1, ADDR_DEV_MASK, 8'h00, DEV_MASK_RST);
		reg_rw(1'b0, 1'b1, ADDR_OV_MASK, 8'h00, OV_MASK_RST);
		pin_is(1'b1);
		foreach (rows[i]) begin
			reg_rw(1'b1, 1'b0, ADDR_DEV_MASK, rows[i].dm, RDATA_IDLE);
			reg_rw(1'b1, 1'b0, ADDR_OV_MASK, rows[i].om, RDATA_IDLE);
			fault_in = rows[i].flt;
			{bus_error, beo, ovo, safe} = {rows[i].be, rows[i].beo, rows[i].ovo, rows[i].safe};
			pin_is(rows[i].pin);
			check({6'h00, be_en, ov_det_en}, {6'h00, ~rows[i].beo, ~rows[i].ovo});
		end
		// Unused bits, simultaneous strobes, unmapped place
		reg_rw(1'b1, 1'b0, ADDR_DEV_MASK, 8'hFF, RDATA_IDLE);
		reg_rw(1'b1, 1'b1, ADDR_DEV_MASK, 8'hFF, DEV_MASK_IMPL);
		// Back-to-back write and read of the rail mask
		pimb_host_inst.write_read(ADDR_OV_MASK, 8'hFA, wr_ack, rd_ack, rd_val);
		check({6'h00, wr_ack, rd_ack}, 8'h03);
		check(rd_val, 8'hFA & OV_MASK_IMPL);
		reg_rw(1'b1, 1'b0, ADDR_OV_MASK, 8'hFF, RDATA_IDLE);
		reg_rw(1'b0, 1'b1, ADDR_OV_MASK, 8'h00, OV_MASK_IMPL);
		reg_rw(1'b1, 1'b0, 8'h1B, 8'hFF, RDATA_IDLE);
		reg_rw(1'b0, 1'b1, 8'h1B, 8'h00, RDATA_IDLE);
		// All faults masked, then forced low for exactly the forced span
		fault_in = 7'h7F;
		safe = 4'h0;
		pin_is(1'b1);
		force_low = 1'b1;
		@(negedge mclk);
		check({7'h00, interrupt_out_n}, 8'h00);
		force_low = 1'b0;
		@(negedge mclk);
		check({7'h00, interrupt_out_n}, 8'h01);
		// Second reset in mid-run clears masks and releases the pin
		force_low = 1'b1;
		pin_is(1'b0);
		arst_n = 1'b0;
		force_low = 1'b0;
		fault_in = '0;
		#1;
		check({7'h00, interrupt_out_n}, 8'h01);
		repeat (3) @(negedge mclk);
		arst_n = 1'b1;
		repeat (3) @(negedge mclk);
		reg_rw(1'b0, 1'b1, ADDR_OV_MASK, 8'h00, OV_MASK_RST);
		reg_rw(1'b0, 1'b1, ADDR_DEV_MASK, 8'h00, DEV_MASK_RST);
		pin_is(1'b1);
		finish_test();
	end
endmodule
`default_nettype wire
